// ==== include/gvu_pkg.sv ====
// Constants, types and register layout of the grouped interrupt vector unit.
// Assumes one 100 MHz aclk; peripheral sources arrive from other clocks.
package gvu_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int AW   = 12;
	localparam int NE   = 8;
	localparam int NL   = 16;
	localparam int NLG  = 5;
	localparam int NB   = 32;
	localparam int NA   = 16;
	localparam int NVB  = 80;
	localparam int NV   = 128;
	localparam int NG   = 7;
	localparam int VFIRST = 128;

	// Group request bit positions
	localparam int GI_CORE = 0;
	localparam int GI_BE   = 1;
	localparam int GI_BL0  = 2;
	localparam int GI_AL0  = 5;

	// Fixed detection method per routable source, 1 = edge
	localparam logic [NB-1:0] SRC_B_EDGE = 32'h0000_ffff;
	localparam logic [NA-1:0] SRC_A_EDGE = 16'h00ff;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [AW-1:0] OFF_EXT   = 12'h000;
	localparam logic [AW-1:0] OFF_INT   = 12'h004;
	localparam logic [AW-1:0] OFF_FAST  = 12'h008;
	localparam logic [AW-1:0] OFF_GUARD = 12'h00c;
	localparam logic [AW-1:0] OFF_EREQ0 = 12'h010;
	localparam logic [AW-1:0] OFF_EREQ1 = 12'h014;
	localparam logic [AW-1:0] OFF_EEN0  = 12'h018;
	localparam logic [AW-1:0] OFF_EEN1  = 12'h01c;
	localparam logic [AW-1:0] OFF_LREQ  = 12'h020;
	localparam logic [AW-1:0] OFF_LREQE = 12'h034;
	localparam logic [AW-1:0] OFF_LEN   = 12'h040;
	localparam logic [AW-1:0] OFF_LENE  = 12'h054;
	localparam logic [AW-1:0] OFF_SEL   = 12'h200;

	// Guard key in bits 15:8 of a guard write
	localparam logic [7:0]  GUARD_KEY = 8'ha5;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_ERR  = 2'h2;

	// Exception table slots, in words from the table base
	localparam logic [7:0] SLOT_PRIV   = 8'h14;
	localparam logic [7:0] SLOT_ACCESS = 8'h15;
	localparam logic [7:0] SLOT_UNDEF  = 8'h17;
	localparam logic [7:0] SLOT_FPU    = 8'h19;
	localparam logic [7:0] SLOT_NMI    = 8'h1e;
	localparam logic [7:0] SLOT_RESET  = 8'h1f;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		exc_undef, exc_priv, exc_access, exc_fpu, exc_reset,
		exc_nmi, exc_int, exc_fast, exc_trap
	} gvu_exc_t;

	typedef enum logic [1:0] {ctx_none, ctx_rte, ctx_fast_return_instr, ctx_nmi} gvu_ctx_t;

	typedef enum logic {ret_exc, ret_fast} gvu_ret_t;

	typedef struct packed {
		logic [NE-1:0]          edge_b;
		logic [NLG-1:0][NL-1:0] lvl;
		logic [NB-1:0]          src_b;
		logic [NA-1:0]          src_a;
	} gvu_async_t;

endpackage : gvu_pkg

// ==== verification/gvu_core_model.sv ====
// Processor core model: takes events, returns from handlers, accepts vectors.
// Assumes the unit answers one edge after each strobe, as on aclk.
`timescale 1ns/100ps
module gvu_core_model
	import gvu_pkg::*;
(
	input  wire logic        aclk,
	output logic             exc_valid,
	output gvu_exc_t         exc_kind,
	output logic [7:0]       exc_vec,
	output logic             ret_valid,
	output gvu_ret_t         ret_instr,
	output logic             ack_valid,
	output logic [7:0]       ack_vec,
	input  wire logic        fetch_valid,
	input  wire logic [31:0] fetch_addr,
	input  wire logic        ret_ok,
	input  wire logic        ret_fault
);
	initial begin
		exc_valid = 1'b0;
		exc_kind  = exc_undef;
		exc_vec   = 8'h00;
		ret_valid = 1'b0;
		ret_instr = ret_exc;
		ack_valid = 1'b0;
		ack_vec   = 8'h00;
	end

	// The vector, not the kind, is scrambled once released so a stale value never looks valid
	task take(input gvu_exc_t k, input logic [7:0] v, output logic fv, output logic [31:0] fa);
		@(posedge aclk);
		exc_valid <= 1'b1;
		exc_kind  <= k;
		exc_vec   <= v;
		@(posedge aclk);
		exc_valid <= 1'b0;
		exc_vec   <= ~v;
		#1;
		fv = fetch_valid;
		fa = fetch_addr;
	endtask : take

	// The caller never returns after a non-maskable event; after reset only on purpose
	task give_ret(input gvu_ret_t r, output logic ok, output logic flt);
		@(posedge aclk);
		ret_valid <= 1'b1;
		ret_instr <= r;
		@(posedge aclk);
		ret_valid <= 1'b0;
		#1;
		ok  = ret_ok;
		flt = ret_fault;
	endtask : give_ret

	task give_ack(input logic [7:0] v);
		@(posedge aclk);
		ack_valid <= 1'b1;
		ack_vec   <= v;
		@(posedge aclk);
		ack_valid <= 1'b0;
		ack_vec   <= ~v;
	endtask : give_ack
endmodule : gvu_core_model

// ==== verification/tb_grouped_interrupt_vector_unit.sv ====
// Self-checking bench: AXI4-Lite master, core model, random peripheral sources.
// Assumes the package offsets and the one-clock unit described in the hand-over.
`timescale 1ns/100ps
module tb_grouped_interrupt_vector_unit
	import gvu_pkg::*;
;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, exc_valid, ret_valid, ack_valid;
	logic fetch_valid, ret_ok, ret_fault, fv, ok, flt;
	logic [AW-1:0] awaddr, araddr;
	logic [31:0]   wdata, rdata, fetch_addr, fa, eb, ib, fvr, d;
	logic [3:0]    wstrb;
	logic [1:0]    bresp, rresp, r;
	logic [NE-1:0] core_edge_src;
	logic [7:0]    exc_vec, ack_vec;
	logic [NG-1:0] grp_req;
	logic [NV-1:0] vec_req;
	logic [15:0]   m;
	gvu_async_t    periph_src;
	gvu_exc_t      exc_kind, k;
	gvu_ret_t      ret_instr;
	int            num_errors, samples_checked, i, s, v;

	gvu_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.core_edge_src(core_edge_src), .periph_src(periph_src), .exc_valid(exc_valid),
		.exc_kind(exc_kind), .exc_vec(exc_vec), .ret_valid(ret_valid),
		.ret_instr(ret_instr), .ack_valid(ack_valid), .ack_vec(ack_vec),
		.grp_req(grp_req), .vec_req(vec_req), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .ret_ok(ret_ok), .ret_fault(ret_fault));

	gvu_core_model core (.aclk(aclk), .exc_valid(exc_valid), .exc_kind(exc_kind),
		.exc_vec(exc_vec), .ret_valid(ret_valid), .ret_instr(ret_instr),
		.ack_valid(ack_valid), .ack_vec(ack_vec), .fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr), .ret_ok(ret_ok), .ret_fault(ret_fault));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task stop_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask : chk

	task hung;
		$display("[ERR] bus wait expected answer seen none");
		num_errors++;
		stop_test();
	endtask : hung

	task wr(input logic [AW-1:0] a, input logic [31:0] x, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= x;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (n == 40) hung();
		rs = bresp;
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [AW-1:0] a, output logic [31:0] x, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (n == 40) hung();
		x = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd

	function automatic logic [31:0] exp_fetch(gvu_exc_t e, logic [7:0] vn);
		case (e)
			exc_int, exc_trap: return ib + {22'h0, vn, 2'b00};
			exc_fast:  return fvr;
			exc_priv:  return eb + {22'h0, SLOT_PRIV, 2'b00};
			exc_access: return eb + {22'h0, SLOT_ACCESS, 2'b00};
			exc_fpu:   return eb + {22'h0, SLOT_FPU, 2'b00};
			exc_nmi:   return eb + {22'h0, SLOT_NMI, 2'b00};
			exc_reset: return eb + {22'h0, SLOT_RESET, 2'b00};
			default:   return eb + {22'h0, SLOT_UNDEF, 2'b00};
		endcase
	endfunction : exp_fetch

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		num_errors = 0;
		samples_checked = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = '0;
		araddr = '0;
		wdata = 32'h0;
		wstrb = 4'hf;
		core_edge_src = '0;
		periph_src = '0;
		void'($urandom(32'h3918));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("awready", 32'h1, 32'(awready));
		rd(OFF_EXT, d, r);
		chk("ext reset", RST_WORD, d);
		rd(12'h100, d, r);
		chk("rresp unmapped", 32'(RESP_ERR), 32'(r));
		wr(12'h100, 32'h1, r);
		chk("bresp unmapped", 32'(RESP_ERR), 32'(r));
		eb  = $urandom() & 32'hffff_fffc;
		ib  = $urandom() & 32'hffff_fffc;
		fvr = $urandom() & 32'hffff_fffc;
		wr(OFF_EXT, eb, r);
		wr(OFF_INT, ib, r);
		wr(OFF_FAST, fvr, r);
		rd(OFF_FAST, d, r);
		chk("fast readback", fvr, d);
		for (i = 0; i < 9; i++) begin
			k = gvu_exc_t'(i);
			v = $urandom_range(0, 255);
			core.take(k, 8'(v), fv, fa);
			chk("fetch valid", 32'h1, 32'(fv));
			chk("fetch", exp_fetch(k, 8'(v)), fa);
			if (k != exc_nmi) begin
				core.give_ret(k == exc_fast ? ret_fast : ret_exc, ok, flt);
				chk("ret ok", 32'(k != exc_reset), 32'(ok));
			end
		end
		// Wrong return kind after an ordinary and after a fast entry
		for (i = 0; i < 2; i++) begin
			core.take(i ? exc_fast : exc_int, 8'h40, fv, fa);
			core.give_ret(i ? ret_exc : ret_fast, ok, flt);
			chk("ret wrong", 32'h1, 32'(flt));
		end
		for (i = 0; i < NLG; i++) begin
			m = 16'($urandom_range(1, 65535));
			periph_src.lvl[i] <= m;
			wr(OFF_LEN + AW'(4 * i), {16'h0, m}, r);
			repeat (6) @(posedge aclk);
			chk("level grp", 32'h1, 32'(grp_req[GI_BL0 + i]));
			rd(OFF_LREQ + AW'(4 * i), d, r);
			chk("level req", {16'h0, m}, d);
			wr(OFF_LEN + AW'(4 * i), 32'h0, r);
			repeat (3) @(posedge aclk);
			chk("level masked", 32'h0, 32'(grp_req[GI_BL0 + i]));
			periph_src.lvl[i] <= '0;
		end
		for (i = 0; i < 2; i++) begin
			s = $urandom_range(0, NE - 1);
			wr(OFF_EEN0 + AW'(4 * i), 32'h0000_00ff, r);
			if (i == 0) core_edge_src[s] <= 1'b1;
			else periph_src.edge_b[s] <= 1'b1;
			repeat (6) @(posedge aclk);
			chk("edge grp", 32'h1, 32'(grp_req[i]));
			wr(OFF_EREQ0 + AW'(4 * i), 32'h1 << s, r);
			repeat (3) @(posedge aclk);
			chk("edge cleared", 32'h0, 32'(grp_req[i]));
			core_edge_src <= '0;
			periph_src.edge_b <= '0;
		end
		v = $urandom_range(0, NVB - 1);
		s = $urandom_range(0, 15);
		wr(OFF_SEL + AW'(4 * v), 32'(s + 1), r);
		rd(OFF_SEL + AW'(4 * v), d, r);
		chk("sel guarded", 32'h0, d);
		periph_src.src_b[s] <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("no select", 32'h0, 32'(vec_req[v]));
		periph_src.src_b[s] <= 1'b0;
		wr(OFF_SEL, 32'(NB), r);
		wr(OFF_GUARD, {16'h0, GUARD_KEY, 8'h01}, r);
		wr(OFF_SEL + AW'(4 * v), 32'(s + 1), r);
		rd(OFF_SEL + AW'(4 * v), d, r);
		chk("sel open", 32'(s + 1), d);
		repeat (3) @(posedge aclk);
		periph_src.src_b[s] <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("vec b", 32'h1, 32'(vec_req[v]));
		core.give_ack(8'(VFIRST + v));
		repeat (2) @(posedge aclk);
		chk("vec b acked", 32'h0, 32'(vec_req[v]));
		// Corner: highest clock-B source, level sensed, on the lowest vector
		wr(OFF_SEL, 32'(NB), r);
		periph_src.src_b[NB-1] <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("vec b level", 32'h1, 32'(vec_req[0]));
		// Second pass is the corner: highest clock-A source on vector 255
		for (i = 0; i < 2; i++) begin
			v = i ? NV - 1 : NVB + $urandom_range(0, NV - NVB - 1);
			s = i ? NA - 1 : $urandom_range(8, 15);
			wr(OFF_SEL + AW'(4 * v), 32'(s + 1), r);
			periph_src.src_a[s] <= 1'b1;
			repeat (6) @(posedge aclk);
			chk("vec a", 32'h1, 32'(vec_req[v]));
			periph_src.src_a[s] <= 1'b0;
			repeat (6) @(posedge aclk);
			chk("vec a level", 32'h0, 32'(vec_req[v]));
		end
		stop_test();
	end
endmodule : tb_grouped_interrupt_vector_unit

// ==== verilog/gvu_sync.sv ====
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a level held for several aclk periods.
`timescale 1ns/100ps
module gvu_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// Only the second stage may read meta_r
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= d;
			q_r    <= meta_r;
		end
	end

	assign q = q_r;

endmodule : gvu_sync

// ==== verilog/gvu_top.sv ====
// Grouped interrupt vector unit: group requests, configurable vector
// routing, vector fetch selection and return checking, AXI4-Lite slave.
// Assumes processor strobes are on aclk; peripheral sources are not.
`timescale 1ns/100ps
module gvu_top
	import gvu_pkg::*;
(
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire logic [AW-1:0]   awaddr,
	input  wire logic            awvalid,
	output logic                 awready,
	input  wire logic [31:0]     wdata,
	input  wire logic [3:0]      wstrb,
	input  wire logic            wvalid,
	output logic                 wready,
	output logic [1:0]           bresp,
	output logic                 bvalid,
	input  wire logic            bready,
	input  wire logic [AW-1:0]   araddr,
	input  wire logic            arvalid,
	output logic                 arready,
	output logic [31:0]          rdata,
	output logic [1:0]           rresp,
	output logic                 rvalid,
	input  wire logic            rready,
	input  wire logic [NE-1:0]   core_edge_src,
	input  wire gvu_async_t      periph_src,
	input  wire logic            exc_valid,
	input  wire gvu_exc_t        exc_kind,
	input  wire logic [7:0]      exc_vec,
	input  wire logic            ret_valid,
	input  wire gvu_ret_t        ret_instr,
	input  wire logic            ack_valid,
	input  wire logic [7:0]      ack_vec,
	output logic [NG-1:0]        grp_req,
	output logic [NV-1:0]        vec_req,
	output logic                 fetch_valid,
	output logic [31:0]          fetch_addr,
	output logic                 ret_ok,
	output logic                 ret_fault
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	gvu_async_t             async_s;
	gvu_async_t             prev_r;
	logic [NE-1:0]          core_prev_r;
	logic [NB-1:0]          rise_b;
	logic [NA-1:0]          rise_a;

	logic                   awready_r, awready_nxt;
	logic                   wready_r, wready_nxt;
	logic                   bvalid_r, bvalid_nxt;
	logic [1:0]             bresp_r, bresp_nxt;
	logic [AW-1:0]          awa_r, awa_nxt;
	logic [31:0]            wd_r, wd_nxt;
	logic [3:0]             ws_r, ws_nxt;
	logic                   arready_r, arready_nxt;
	logic                   rvalid_r, rvalid_nxt;
	logic [31:0]            rdata_r, rdata_nxt;
	logic [1:0]             rresp_r, rresp_nxt;
	logic                   wr_go;
	logic [AW-1:0]          wa;
	logic [AW-1:0]          ra;

	logic [31:0]            ext_r, ext_nxt;
	logic [31:0]            int_r, int_nxt;
	logic [31:0]            fast_r, fast_nxt;
	logic                   guard_r, guard_nxt;
	logic [1:0][NE-1:0]     ereq_r, ereq_nxt;
	logic [1:0][NE-1:0]     een_r, een_nxt;
	logic [NLG-1:0][NL-1:0] len_r, len_nxt;
	logic [7:0]             sel_r [NV];
	logic [7:0]             sel_nxt [NV];

	logic [NG-1:0]          grp_r, grp_nxt;
	logic [NV-1:0]          vreq_r, vreq_nxt;
	logic                   fv_r, fv_nxt;
	logic [31:0]            fa_r, fa_nxt;
	logic                   rok_r, rok_nxt;
	logic                   rflt_r, rflt_nxt;
	gvu_ctx_t               ctx_r, ctx_nxt;

	function automatic logic [31:0] gvu_merge(input logic [31:0] o,
			input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction : gvu_merge

	// ----------------------------------------------------------------
	// Source capture
	// ----------------------------------------------------------------
	gvu_sync #(
		.W ($bits(gvu_async_t))
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (periph_src),
		.q       (async_s)
	);

	// Edge sources remember their last sample; core sources share aclk
	assign rise_b = async_s.src_b & ~prev_r.src_b & SRC_B_EDGE;
	assign rise_a = async_s.src_a & ~prev_r.src_a & SRC_A_EDGE;

	// ----------------------------------------------------------------
	// AXI4-Lite slave and register file
	// ----------------------------------------------------------------
	assign wr_go = !awready_r && !wready_r && !bvalid_r;
	assign wa    = {awa_r[AW-1:2], 2'b00};
	assign ra    = {araddr[AW-1:2], 2'b00};

	always_comb begin
		awready_nxt = awready_r;
		wready_nxt  = wready_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		awa_nxt     = awa_r;
		wd_nxt      = wd_r;
		ws_nxt      = ws_r;
		ext_nxt     = ext_r;
		int_nxt     = int_r;
		fast_nxt    = fast_r;
		guard_nxt   = guard_r;
		een_nxt     = een_r;
		len_nxt     = len_r;
		sel_nxt     = sel_r;
		// Hardware sets win over software clears below
		ereq_nxt[0] = ereq_r[0];
		ereq_nxt[1] = ereq_r[1];
		if (awvalid && awready_r) begin
			awready_nxt = 1'b0;
			awa_nxt     = awaddr;
		end
		if (wvalid && wready_r) begin
			wready_nxt = 1'b0;
			wd_nxt     = wdata;
			ws_nxt     = wstrb;
		end
		if (wr_go) begin
			bvalid_nxt = 1'b1;
			bresp_nxt  = RESP_OK;
			if (wa == OFF_EXT) begin
				ext_nxt = gvu_merge(ext_r, wd_r, ws_r);
			end else if (wa == OFF_INT) begin
				int_nxt = gvu_merge(int_r, wd_r, ws_r);
			end else if (wa == OFF_FAST) begin
				fast_nxt = gvu_merge(fast_r, wd_r, ws_r);
			end else if (wa == OFF_GUARD) begin
				// Key keeps a stray write from opening the guard
				if (ws_r[1] && ws_r[0] && wd_r[15:8] == GUARD_KEY) begin
					guard_nxt = wd_r[0];
				end
			end else if (wa == OFF_EREQ0 || wa == OFF_EREQ1) begin
				if (ws_r[0]) begin
					ereq_nxt[wa[2]] = ereq_r[wa[2]] & ~wd_r[NE-1:0];
				end
			end else if (wa == OFF_EEN0 || wa == OFF_EEN1) begin
				if (ws_r[0]) begin
					een_nxt[wa[2]] = wd_r[NE-1:0];
				end
			end else if (wa >= OFF_LREQ && wa < OFF_LREQE) begin
				bresp_nxt = RESP_OK;
			end else if (wa >= OFF_LEN && wa < OFF_LENE) begin
				len_nxt[wa[4:2]] = NL'(gvu_merge(32'(len_r[wa[4:2]]),
					wd_r, ws_r));
			end else if (wa >= OFF_SEL) begin
				if (guard_r && ws_r[0]) begin
					sel_nxt[wa[8:2]] = wd_r[7:0];
				end
			end else begin
				bresp_nxt = RESP_ERR;
			end
		end
		if (bvalid_r && bready) begin
			bvalid_nxt  = 1'b0;
			awready_nxt = 1'b1;
			wready_nxt  = 1'b1;
		end
		ereq_nxt[0] = ereq_nxt[0] | (core_edge_src & ~core_prev_r);
		ereq_nxt[1] = ereq_nxt[1] | (async_s.edge_b & ~prev_r.edge_b);
	end

	always_comb begin
		arready_nxt = arready_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		if (arvalid && arready_r) begin
			arready_nxt = 1'b0;
			rvalid_nxt  = 1'b1;
			rresp_nxt   = RESP_OK;
			rdata_nxt   = RST_WORD;
			if (ra == OFF_EXT) begin
				rdata_nxt = ext_r;
			end else if (ra == OFF_INT) begin
				rdata_nxt = int_r;
			end else if (ra == OFF_FAST) begin
				rdata_nxt = fast_r;
			end else if (ra == OFF_GUARD) begin
				rdata_nxt = 32'(guard_r);
			end else if (ra == OFF_EREQ0 || ra == OFF_EREQ1) begin
				rdata_nxt = 32'(ereq_r[ra[2]]);
			end else if (ra == OFF_EEN0 || ra == OFF_EEN1) begin
				rdata_nxt = 32'(een_r[ra[2]]);
			end else if (ra >= OFF_LREQ && ra < OFF_LREQE) begin
				rdata_nxt = 32'(async_s.lvl[ra[4:2]]);
			end else if (ra >= OFF_LEN && ra < OFF_LENE) begin
				rdata_nxt = 32'(len_r[ra[4:2]]);
			end else if (ra >= OFF_SEL) begin
				rdata_nxt = 32'(sel_r[ra[8:2]]);
			end else begin
				rresp_nxt = RESP_ERR;
			end
		end else if (rvalid_r && rready) begin
			rvalid_nxt  = 1'b0;
			arready_nxt = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Group requests
	// ----------------------------------------------------------------
	always_comb begin
		grp_nxt[GI_CORE] = |(ereq_r[0] & een_r[0]);
		grp_nxt[GI_BE]   = |(ereq_r[1] & een_r[1]);
		for (int g = 0; g < NLG; g++) begin
			grp_nxt[GI_BL0 + g] = |(async_s.lvl[g] & len_r[g]);
		end
	end

	// ----------------------------------------------------------------
	// Configurable vectors 128 to 255, one slot each
	// ----------------------------------------------------------------
	for (genvar k = 0; k < NV; k++) begin : g_slot
		logic [7:0] sb;
		logic       hit;
		logic       lv;
		logic       rs;
		logic       ed;
		logic       pend_r, pend_nxt;

		always_comb begin
			sb = sel_r[k] - 8'h01;
			if (k < NVB) begin
				hit = sel_r[k] != 8'h00 && sel_r[k] <= 8'(NB);
				lv  = async_s.src_b[sb[4:0]];
				rs  = rise_b[sb[4:0]];
				ed  = SRC_B_EDGE[sb[4:0]];
			end else begin
				hit = sel_r[k] != 8'h00 && sel_r[k] <= 8'(NA);
				lv  = async_s.src_a[sb[3:0]];
				rs  = rise_a[sb[3:0]];
				ed  = SRC_A_EDGE[sb[3:0]];
			end
			pend_nxt = pend_r;
			if (ack_valid && ack_vec == 8'(VFIRST + k)) begin
				pend_nxt = 1'b0;
			end
			if (rs) begin
				pend_nxt = 1'b1;
			end
			if (!hit) begin
				pend_nxt = 1'b0;
			end
			vreq_nxt[k] = hit && (ed ? pend_r : lv);
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pend_r <= 1'b0;
			end else begin
				pend_r <= pend_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// Vector fetch selection and return checking
	// ----------------------------------------------------------------
	always_comb begin
		fv_nxt   = 1'b0;
		fa_nxt   = fa_r;
		rok_nxt  = 1'b0;
		rflt_nxt = 1'b0;
		ctx_nxt  = ctx_r;
		if (ret_valid) begin
			rok_nxt = (ctx_r == ctx_rte && ret_instr == ret_exc)
				|| (ctx_r == ctx_fast_return_instr && ret_instr == ret_fast);
			rflt_nxt = !rok_nxt;
			ctx_nxt  = ctx_none;
		end
		if (exc_valid) begin
			fv_nxt  = 1'b1;
			ctx_nxt = ctx_rte;
			case (exc_kind)
				exc_undef: fa_nxt = ext_r + {22'h0, SLOT_UNDEF, 2'b00};
				exc_priv: fa_nxt = ext_r + {22'h0, SLOT_PRIV, 2'b00};
				exc_access: fa_nxt = ext_r + {22'h0, SLOT_ACCESS, 2'b00};
				exc_fpu: fa_nxt = ext_r + {22'h0, SLOT_FPU, 2'b00};
				exc_reset: begin
					fa_nxt  = ext_r + {22'h0, SLOT_RESET, 2'b00};
					ctx_nxt = ctx_none;
				end
				exc_nmi: begin
					fa_nxt  = ext_r + {22'h0, SLOT_NMI, 2'b00};
					ctx_nxt = ctx_nmi;
				end
				exc_fast: begin
					fa_nxt  = fast_r;
					ctx_nxt = ctx_fast_return_instr;
				end
				default: fa_nxt = int_r + {22'h0, exc_vec, 2'b00};
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r   <= 1'b1;
			wready_r    <= 1'b1;
			bvalid_r    <= 1'b0;
			bresp_r     <= RESP_OK;
			awa_r       <= '0;
			wd_r        <= RST_WORD;
			ws_r        <= 4'h0;
			arready_r   <= 1'b1;
			rvalid_r    <= 1'b0;
			rdata_r     <= RST_WORD;
			rresp_r     <= RESP_OK;
			ext_r       <= RST_WORD;
			int_r       <= RST_WORD;
			fast_r      <= RST_WORD;
			guard_r     <= 1'b0;
			ereq_r      <= '0;
			een_r       <= '0;
			len_r       <= '0;
			sel_r       <= '{default: 8'h00};
			prev_r      <= '0;
			core_prev_r <= '0;
			grp_r       <= '0;
			vreq_r      <= '0;
			fv_r        <= 1'b0;
			fa_r        <= RST_WORD;
			rok_r       <= 1'b0;
			rflt_r      <= 1'b0;
			ctx_r       <= ctx_none;
		end else begin
			awready_r   <= awready_nxt;
			wready_r    <= wready_nxt;
			bvalid_r    <= bvalid_nxt;
			bresp_r     <= bresp_nxt;
			awa_r       <= awa_nxt;
			wd_r        <= wd_nxt;
			ws_r        <= ws_nxt;
			arready_r   <= arready_nxt;
			rvalid_r    <= rvalid_nxt;
			rdata_r     <= rdata_nxt;
			rresp_r     <= rresp_nxt;
			ext_r       <= ext_nxt;
			int_r       <= int_nxt;
			fast_r      <= fast_nxt;
			guard_r     <= guard_nxt;
			ereq_r      <= ereq_nxt;
			een_r       <= een_nxt;
			len_r       <= len_nxt;
			sel_r       <= sel_nxt;
			prev_r      <= async_s;
			core_prev_r <= core_edge_src;
			grp_r       <= grp_nxt;
			vreq_r      <= vreq_nxt;
			fv_r        <= fv_nxt;
			fa_r        <= fa_nxt;
			rok_r       <= rok_nxt;
			rflt_r      <= rflt_nxt;
			ctx_r       <= ctx_nxt;
		end
	end

	assign awready     = awready_r;
	assign wready      = wready_r;
	assign bvalid      = bvalid_r;
	assign bresp       = bresp_r;
	assign arready     = arready_r;
	assign rvalid      = rvalid_r;
	assign rdata       = rdata_r;
	assign rresp       = rresp_r;
	assign grp_req     = grp_r;
	assign vec_req     = vreq_r;
	assign fetch_valid = fv_r;
	assign fetch_addr  = fa_r;
	assign ret_ok      = rok_r;
	assign ret_fault   = rflt_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Any enabled member edge, with no register write landing behind it
	sequence s_core_rise;
		(|(core_edge_src & ~core_prev_r & een_r[0])) && !wr_go ##1 !wr_go;
	endsequence

	sequence s_b_rise;
		(|(async_s.edge_b & ~prev_r.edge_b & een_r[1])) && !wr_go ##1 !wr_go;
	endsequence

	sequence s_fast_entry;
		exc_valid && exc_kind == exc_fast && !ret_valid;
	endsequence

	sequence s_reset_entry;
		exc_valid && exc_kind == exc_reset && !ret_valid;
	endsequence

	sequence s_lone_ret(gvu_ret_t i);
		ret_valid && ret_instr == i && !exc_valid;
	endsequence

	chk_core_edge_group: assert property (s_core_rise |=> grp_r[GI_CORE])
		else $error("core edge did not raise group request");
	chk_edge_b_group: assert property (s_b_rise |=> grp_r[GI_BE])
		else $error("clock-B edge group request missing");
	chk_level_b_group: assert property (|(async_s.lvl[0] & len_r[0]) |=> grp_r[GI_BL0])
		else $error("clock-B level group request missing");
	chk_level_a_quiet: assert property (len_r[4] == '0 |=> !grp_r[GI_AL0 + 1])
		else $error("masked clock-A group still requests");
	chk_route_b_level: assert property (sel_r[0] == 8'(NB) && async_s.src_b[NB-1]
		|=> vreq_r[0])
		else $error("clock-B level source not routed to vector 128");
	chk_route_a_level: assert property (sel_r[NV-1] == 8'(NA) && async_s.src_a[NA-1]
		|=> vreq_r[NV-1])
		else $error("clock-A level source not routed to vector 255");
	chk_unsel_silent: assert property (sel_r[1] == 8'h00 |=> !vreq_r[1])
		else $error("unselected vector requested");
	chk_guard_blocks_sel: assert property (wr_go && !guard_r && wa == OFF_SEL
		|=> $stable(sel_r[0]))
		else $error("source select changed while guarded");
	chk_nmi_table: assert property (exc_valid && exc_kind == exc_nmi
		|=> fv_r && fa_r == $past(ext_r) + {22'h0, SLOT_NMI, 2'b00})
		else $error("NMI vector not from exception table");
	chk_int_table: assert property (exc_valid && exc_kind == exc_int
		|=> fa_r == $past(int_r) + {22'h0, $past(exc_vec), 2'b00})
		else $error("interrupt vector not from interrupt table");
	chk_fast_return: assert property (s_fast_entry ##1 (!exc_valid && !ret_valid)
		##1 s_lone_ret(ret_exc) |=> rflt_r && !rok_r)
		else $error("fast handler accepted exception return");
	chk_reset_no_ret: assert property (s_reset_entry ##1 (!exc_valid && !ret_valid)
		##1 s_lone_ret(ret_exc) |=> rflt_r)
		else $error("return after reset was accepted");

endmodule : gvu_top
